// File: rtl/apbr_cfg.svh
// Constants of the register access block: address map, widths, reset values.
// Assumes it is included by the package and the design modules only.
`ifndef APBR_CFG_SVH
`define APBR_CFG_SVH

`define APBR_ADDR_W 8
`define APBR_NUM_REGS 4
`define APBR_REG_W 33
`define APBR_WORD_BYTES 3'h4
`define APBR_RESET_VAL 33'h000000000
`define APBR_PRDATA_RESET 32'h00000000
`define APBR_ADDR_LSB 2

`endif

// File: rtl/apbr_pkg.sv
// Types shared by the register access block.
// Assumes apbr_cfg.svh sits on the include path.
`include "apbr_cfg.svh"

package apbr_pkg;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [`APBR_ADDR_W-1:0] paddr;
    } apbr_ctl_type;

    typedef enum logic [2:0] {
        APBR_IDLE = 3'h1,
        APBR_SETUP = 3'h2,
        APBR_ACCESS = 3'h4
    } apbr_phase_type;

endpackage

// File: rtl/apbr_bank.sv
// Register storage with per-byte write enables; register values are driven straight from the storage.
// Assumes one clock and the enables below come from the access decoder.
`timescale 1ns/1ps
`include "apbr_cfg.svh"

module apbr_bank #(
    parameter int NUM_REGS = `APBR_NUM_REGS,
    parameter int REG_W = `APBR_REG_W,
    parameter int NBYTES = (REG_W + 7) / 8
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic [NUM_REGS-1:0] reg_sel,
    input wire logic [NBYTES-1:0] byte_we,
    input wire logic [NBYTES*8-1:0] wr_data,
    output logic [NUM_REGS*REG_W-1:0] reg_values
);

    logic [NBYTES*8-1:0] mem [NUM_REGS];

    genvar gr;
    genvar gb;
    generate
        for (gr = 0; gr < NUM_REGS; gr++) begin : g_reg
            for (gb = 0; gb < NBYTES; gb++) begin : g_byte
                always_ff @(posedge sys_clk or negedge nrst) begin
                    if (!nrst) begin
                        mem[gr][gb*8 +: 8] <= 8'h00;
                    end else if (reg_sel[gr] && byte_we[gb]) begin
                        mem[gr][gb*8 +: 8] <= wr_data[gb*8 +: 8];
                    end
                end
            end
            assign reg_values[gr*REG_W +: REG_W] = mem[gr][REG_W-1:0];
        end
    endgenerate

endmodule

// File: rtl/apbr_slave.sv
// APB slave register access: decode, byte enables, registered read-back.
// Assumes an APB bridge master on sys_clk with no wait states.
//
// Notes on behaviour
// - On 8-bit bus, 25..32-bit registers take four transfers, low byte first.
// - On 8-bit bus every low address bit is decoded to pick a byte.
// - Each transfer: setup with enable low, then access with enable high.
// - Writes commit in the access phase, when enable is high.
// - Write enable needs address match with select, write and enable all high.
// - Wide registers get byte write enables for the low four bytes only on buses up to 32 bits; one write on a 32-bit bus sets 32 bits.
// - Read enable: address match, select high, write and enable low.
// - Read value is captured in a register and driven to the master.
// - The read happens in the setup cycle; data ready for access phase.
// - Outside a read setup cycle the read data holds its last value.
// - Unused addresses and bits read zero; no error is signalled.
// - Writes to bits above a register's width have no effect.
// - Each register sits on a 32-bit aligned address at any bus width.
`timescale 1ns/1ps
`include "apbr_cfg.svh"

module apbr_slave #(
    parameter int DATA_W = 32,
    parameter int NUM_REGS = `APBR_NUM_REGS,
    parameter int REG_W = `APBR_REG_W
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire apbr_pkg::apbr_ctl_type ctl,
    input wire logic [DATA_W-1:0] pwdata,
    output logic [DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [NUM_REGS*REG_W-1:0] reg_values,
    output logic [NUM_REGS-1:0] reg_wr_en,
    output logic [NUM_REGS-1:0] reg_rd_en
);

    localparam int NBYTES = (REG_W + 7) / 8;
    localparam int WORD_W = NBYTES * 8;
    localparam int LANES = DATA_W / 8;
    localparam int LANE_LSB = $clog2(LANES);

    logic wr_access;
    logic rd_setup;
    logic [NUM_REGS-1:0] reg_sel;
    logic [NBYTES-1:0] byte_we;
    logic [WORD_W-1:0] wr_word;
    logic [WORD_W-1:0] rd_word;
    logic [DATA_W-1:0] next_prdata;
    logic [`APBR_ADDR_W-1:0] word_addr;
    logic [`APBR_ADDR_W-1:0] sub_addr;

    assign word_addr = ctl.paddr >> `APBR_ADDR_LSB;
    // low bits kept for byte pick
    assign sub_addr = ctl.paddr & `APBR_ADDR_W'(3);

    genvar gr;
    generate
        for (gr = 0; gr < NUM_REGS; gr++) begin : g_dec
            assign reg_sel[gr] = (word_addr == `APBR_ADDR_W'(gr));
        end
    endgenerate

    assign wr_access = ctl.psel && ctl.penable && ctl.pwrite;
    assign rd_setup = ctl.psel && !ctl.penable && !ctl.pwrite;
    assign reg_wr_en = wr_access ? reg_sel : '0;
    assign reg_rd_en = rd_setup ? reg_sel : '0;

    assign pready = 1'b1;
    assign pslverr = 1'b0;

    always_comb begin
        int base;
        base = 0;
        byte_we = '0;
        wr_word = '0;
        if (LANES < 4) begin
            base = int'(sub_addr) & ~(LANES - 1);
        end
        for (int b = 0; b < LANES; b++) begin
            if (base + b < NBYTES) begin
                byte_we[base + b] = wr_access;
                wr_word[(base + b)*8 +: 8] = pwdata[b*8 +: 8];
            end
        end
    end

    apbr_bank #(
        .NUM_REGS(NUM_REGS),
        .REG_W(REG_W),
        .NBYTES(NBYTES)
    ) u_bank (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .reg_sel(reg_wr_en),
        .byte_we(byte_we),
        .wr_data(wr_word),
        .reg_values(reg_values)
    );

    always_comb begin
        int base;
        base = 0;
        rd_word = '0;
        for (int r = 0; r < NUM_REGS; r++) begin
            if (reg_sel[r]) begin
                rd_word[REG_W-1:0] = reg_values[r*REG_W +: REG_W];
            end
        end
        if (LANES < 4) begin
            base = int'(sub_addr) & ~(LANES - 1);
        end
        next_prdata = '0;
        for (int b = 0; b < LANES; b++) begin
            if (base + b < NBYTES) begin
                next_prdata[b*8 +: 8] = rd_word[(base + b)*8 +: 8];
            end
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            prdata <= '0;
        end else if (rd_setup) begin
            prdata <= next_prdata;
        end
    end

endmodule

// File: test/apbr_master.sv
// Bus master model, one transfer per go pulse.
// Assumes go is raised only outside a setup phase.
`timescale 1ns/1ps
module apbr_master (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic go,
    input wire logic wr,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    output apbr_pkg::apbr_ctl_type ctl,
    output logic [31:0] pwdata
);
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ctl <= '0;
            pwdata <= 32'h0;
        end else if (ctl.psel && !ctl.penable) begin
            ctl.penable <= 1'b1;
        end else begin
            ctl <= go ? {2'b10, wr, addr} : {2'b00, ~ctl.pwrite, ~ctl.paddr};
            pwdata <= go && wr ? wdata : ~pwdata;
        end
    end
endmodule

// File: test/apbr_slave_properties.sv
// Port checker of the register block.
// Assumes a 32-bit bus and four 33-bit registers.
`timescale 1ns/1ps
module apbr_chk (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire apbr_pkg::apbr_ctl_type ctl,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [131:0] reg_values,
    input wire logic [3:0] reg_wr_en,
    input wire logic [3:0] reg_rd_en
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    wire [1:0] ri = ctl.paddr[3:2];
    wire [3:0] hit = ctl.paddr[7:4] == 4'h0 ? 4'h1 << ri : 4'h0;
    wire rd = ctl.psel && !ctl.penable && !ctl.pwrite;
    wire [31:0] sv = reg_values[ri*33 +: 32];
    property p_wen; reg_wr_en == (hit & {4{ctl.psel && ctl.penable && ctl.pwrite}}); endproperty
    a_wen: assert property (p_wen) else $error("wen");
    property p_ren; reg_rd_en == (hit & {4{rd}}); endproperty
    a_ren: assert property (p_ren) else $error("ren");
    property p_wr; |reg_wr_en |=> reg_values[$past(ri)*33 +: 32] == $past(pwdata); endproperty
    a_wr: assert property (p_wr) else $error("commit");
    property p_nowr; !$stable(reg_values) |-> $past(|reg_wr_en); endproperty
    a_nowr: assert property (p_nowr) else $error("stray");
    property p_top; $stable(reg_values[32]); endproperty
    a_top: assert property (p_top) else $error("bit 32");
    property p_rd; rd |=> prdata == ($past(|hit) ? $past(sv) : 32'h0); endproperty
    a_rd: assert property (p_rd) else $error("rdata");
    property p_hold; !rd |=> $stable(prdata); endproperty
    a_hold: assert property (p_hold) else $error("hold");
    property p_ok; pready && !pslverr; endproperty
    a_ok: assert property (p_ok) else $error("resp");
    cover property (rd && hit == 4'h0);
    cover property (|reg_wr_en ##1 rd);
    cover property (reg_wr_en[3]);
endmodule
bind apbr_slave apbr_chk u_chk (.*);

// File: test/apbr_slave_bench.sv
// Random read and write bench of the register block.
// Assumes the master model and the bound checker.
`timescale 1ns/1ps
module apbr_slave_bench;
    logic sys_clk = 1'b0, nrst = 1'b0, go = 1'b0, wr = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0, seed = 32'h825F, prdata, pwdata;
    logic [31:0] mdl [4] = '{default: 32'h0}, exp_q [$];
    apbr_pkg::apbr_ctl_type ctl;
    int bad_count = 0, comparisons = 0;
    always #50 sys_clk = ~sys_clk;
    apbr_master u_apbr_master (.*);
    apbr_slave u_apbr_slave (.*, .pready(), .pslverr(), .reg_values(), .reg_wr_en(),
        .reg_rd_en());
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic wrap_up();
        $display("bad_count %0d comparisons %0d", bad_count, comparisons);
        if (bad_count == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (2000) @(posedge sys_clk);
        bad_count = bad_count + 1;
        wrap_up();
    end
    always @(negedge sys_clk) begin
        if (ctl[10:8] === 3'b110) begin
            comparisons = comparisons + 1;
            if (prdata !== exp_q[0]) begin
                bad_count = bad_count + 1;
                $display("Error prdata expected %h seen %h", exp_q[0], prdata);
            end
            void'(exp_q.pop_front());
        end
    end
    initial begin
        repeat (20) @(posedge sys_clk);
        nrst <= 1'b1;
        repeat (400) begin
            @(posedge sys_clk);
            seed = lfsr(seed);
            go <= 1'b1;
            wr <= seed[0];
            addr <= {3'h0, seed[5:1]};
            wdata <= seed;
            if (seed[0] && !seed[5])
                mdl[seed[4:3]] = seed;
            if (!seed[0])
                exp_q.push_back(seed[5] ? 32'h0 : mdl[seed[4:3]]);
            @(posedge sys_clk);
            go <= 1'b0;
            if (seed[6])
                @(posedge sys_clk);
        end
        repeat (4) @(posedge sys_clk);
        wrap_up();
    end
endmodule
